//--- shared/ttc_pkg.sv
package ttc_pkg;
    // register offsets and reset values
    localparam logic [7:0] TTC_OFS_DUR_RPT  = 8'h22;
    localparam logic [7:0] TTC_OFS_PRESS    = 8'h23;
    localparam logic [7:0] TTC_OFS_AVG      = 8'h24;
    localparam logic [7:0] TTC_RST_DUR_RPT  = 8'hA4;
    localparam logic [7:0] TTC_RST_PRESS    = 8'h07;
    localparam logic [7:0] TTC_RST_AVG      = 8'h39;
    // writable bit masks, reserved bits read as zero
    localparam logic [7:0] TTC_MASK_PRESS   = 8'h0F;
    localparam logic [7:0] TTC_MASK_AVG     = 8'h7F;
    // field positions
    localparam int TTC_HOLD_LSB    = 4;
    localparam int TTC_RPT_LSB     = 0;
    localparam int TTC_PRESS_LSB   = 0;
    localparam int TTC_AVG_LSB     = 4;
    localparam int TTC_SDUR_LSB    = 2;
    localparam int TTC_CYC_LSB     = 0;
    // timing
    localparam int TTC_CLK_NS      = 20;
    localparam int TTC_MS_NS       = 1000000;
    localparam int TTC_MS_CYCLES   = TTC_MS_NS / TTC_CLK_NS;
    localparam int TTC_SAMP_BASE_NS = 320000;
    localparam int TTC_SAMP_CYCLES = TTC_SAMP_BASE_NS / TTC_CLK_NS;
    localparam logic [13:0] TTC_STEP_MS = 14'h0023;
    localparam int TTC_CHANNELS    = 8;

    // register write port
    typedef struct packed {
        logic       wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ttc_reg_req_t;

    // averaged measurement handed out
    typedef struct packed {
        logic        valid;
        logic [2:0]  channel;
        logic [15:0] value;
    } ttc_result_t;

    typedef enum logic [2:0] {
        TTC_ST_SCAN   = 3'b001,
        TTC_ST_SAMPLE = 3'b010,
        TTC_ST_WAIT   = 3'b100
    } ttc_state_t;

    // hold limit decode in ms; the step is not uniform
    function automatic logic [13:0] ttc_hold_ms(input logic [3:0] code);
        case (code)
            4'h0: ttc_hold_ms = 14'h0230;
            4'h1: ttc_hold_ms = 14'h0348;
            4'h2: ttc_hold_ms = 14'h0460;
            4'h3: ttc_hold_ms = 14'h0578;
            4'h4: ttc_hold_ms = 14'h0690;
            4'h5: ttc_hold_ms = 14'h08C0;
            4'h6: ttc_hold_ms = 14'h0AF0;
            4'h7: ttc_hold_ms = 14'h0D20;
            4'h8: ttc_hold_ms = 14'h0F50;
            4'h9: ttc_hold_ms = 14'h1180;
            4'hA: ttc_hold_ms = 14'h15E0;
            4'hB: ttc_hold_ms = 14'h1A40;
            4'hC: ttc_hold_ms = 14'h1EA0;
            4'hD: ttc_hold_ms = 14'h22CA;
            4'hE: ttc_hold_ms = 14'h2760;
            default: ttc_hold_ms = 14'h2BC0;
        endcase
    endfunction : ttc_hold_ms
endpackage : ttc_pkg

//--- logic/ttc_touch_timing.sv
`timescale 1ns/1ns
module ttc_touch_timing #(
    parameter int MS_CYCLES   = ttc_pkg::TTC_MS_CYCLES,
    parameter int SAMP_CYCLES = ttc_pkg::TTC_SAMP_CYCLES
) (
    input  wire logic                 clock,
    input  wire logic                 reset,
    input  wire ttc_pkg::ttc_reg_req_t reg_req,
    output logic [7:0]                rd_data,
    input  wire logic [2:0]           rd_addr_lo,
    input  wire logic [7:0]           rd_addr,
    input  wire logic                 hold_limit_recal_enable,
    input  wire logic [7:0]           active_enable,
    input  wire logic [7:0]           repeat_enable,
    input  wire logic [7:0]           touched,
    input  wire logic [15:0]          sample_value,
    output logic [7:0]                recal_req,
    output logic [7:0]                press_hold_event,
    output logic [7:0]                touch_event,
    output logic [7:0]                repeat_pulse,
    output logic                      sample_start,
    output logic [2:0]                sample_channel,
    output logic [1:0]                sample_duration_sel,
    output logic                      low_power,
    output ttc_pkg::ttc_result_t      result
);
    import ttc_pkg::*;

    logic [7:0] dur_rpt_reg, dur_rpt_next;
    logic [7:0] press_reg, press_next;
    logic [7:0] avg_reg, avg_next;
    logic [7:0] rd_reg, rd_next;

    // register file; reserved bits are masked on write
    always_comb begin
        dur_rpt_next = dur_rpt_reg;
        press_next   = press_reg;
        avg_next     = avg_reg;
        if (reg_req.wr_en) begin
            case (reg_req.addr)
                TTC_OFS_DUR_RPT: dur_rpt_next = reg_req.wdata;
                TTC_OFS_PRESS:   press_next = reg_req.wdata & TTC_MASK_PRESS;
                TTC_OFS_AVG:     avg_next = reg_req.wdata & TTC_MASK_AVG;
                default:         dur_rpt_next = dur_rpt_reg;
            endcase
        end
        case (rd_addr)
            TTC_OFS_DUR_RPT: rd_next = dur_rpt_reg;
            TTC_OFS_PRESS:   rd_next = press_reg;
            TTC_OFS_AVG:     rd_next = avg_reg;
            default:         rd_next = 8'h00; // unmapped reads zero
        endcase
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dur_rpt_reg <= TTC_RST_DUR_RPT;
            press_reg   <= TTC_RST_PRESS;
            avg_reg     <= TTC_RST_AVG;
            rd_reg      <= 8'h00;
        end else begin
            dur_rpt_reg <= dur_rpt_next;
            press_reg   <= press_next;
            avg_reg     <= avg_next;
            rd_reg      <= rd_next;
        end
    end
    assign rd_data = rd_reg;

    // decoded fields
    logic [3:0]  hold_limit_time;
    logic [3:0]  repeat_interval;
    logic [3:0]  press_code;
    logic [2:0]  sample_count_sel;
    logic [1:0]  dur_sel;
    logic [1:0]  cycle_code;
    logic [13:0] hold_ms;
    logic [13:0] repeat_ms;
    logic [13:0] press_ms;
    logic [13:0] cycle_ms;
    assign hold_limit_time  = dur_rpt_reg[TTC_HOLD_LSB +: 4];
    assign hold_ms          = ttc_hold_ms(hold_limit_time);
    assign repeat_interval  = dur_rpt_reg[TTC_RPT_LSB +: 4];
    assign repeat_ms        = 14'({10'h000, repeat_interval} + 14'h0001)
                              * TTC_STEP_MS;
    assign press_code       = press_reg[TTC_PRESS_LSB +: 4];
    assign press_ms         = 14'({10'h000, press_code} + 14'h0001)
                              * TTC_STEP_MS;
    assign sample_count_sel = avg_reg[TTC_AVG_LSB +: 3];
    assign dur_sel          = avg_reg[TTC_SDUR_LSB +: 2];
    assign cycle_code       = avg_reg[TTC_CYC_LSB +: 2];
    assign cycle_ms         = 14'({12'h000, cycle_code} + 14'h0001)
                              * TTC_STEP_MS;

    // millisecond time base shared by the channel timers and the cycle timer
    logic [19:0] ms_cnt_reg, ms_cnt_next;
    logic        ms_tick;
    assign ms_tick = (ms_cnt_reg == 20'(MS_CYCLES - 1));
    always_comb begin
        ms_cnt_next = ms_tick ? 20'h0_0000 : ms_cnt_reg + 20'h0_0001;
    end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) ms_cnt_reg <= 20'h0_0000;
        else       ms_cnt_reg <= ms_cnt_next;
    end

    // per-channel touch duration, hold limit, press and repeat timing
    genvar ch;
    generate
        for (ch = 0; ch < TTC_CHANNELS; ch++) begin : g_ch
            logic [13:0] dur_reg, dur_next;
            logic [13:0] rep_reg, rep_next;
            logic        held_reg, held_next;
            logic        was_reg, was_next;
            logic [3:0]  ev_reg, ev_next; // recal, hold, touch, repeat
            always_comb begin
                dur_next  = dur_reg;
                rep_next  = rep_reg;
                held_next = held_reg;
                was_next  = touched[ch];
                ev_next   = 4'h0;
                if (touched[ch]) begin
                    if (ms_tick && dur_reg != 14'h3FFF) begin
                        dur_next = dur_reg + 14'h0001;
                        if (hold_limit_recal_enable &&
                            dur_next == hold_ms)
                            ev_next[0] = 1'b1;
                        if (repeat_enable[ch] && !held_reg &&
                            dur_reg == press_ms) begin
                            ev_next[1] = 1'b1;
                            held_next  = 1'b1;
                            rep_next   = 14'h0000;
                        end
                    end
                    if (ms_tick && held_reg && repeat_enable[ch]) begin
                        if (rep_reg + 14'h0001 == repeat_ms) begin
                            rep_next   = 14'h0000;
                            ev_next[3] = 1'b1;
                        end else begin
                            rep_next = rep_reg + 14'h0001;
                        end
                    end
                end else begin
                    if (was_reg && repeat_enable[ch] && !held_reg)
                        ev_next[2] = 1'b1;
                    dur_next  = 14'h0000;
                    rep_next  = 14'h0000;
                    held_next = 1'b0;
                end
            end
            always_ff @(posedge clock or posedge reset) begin
                if (reset) begin
                    dur_reg  <= 14'h0000;
                    rep_reg  <= 14'h0000;
                    held_reg <= 1'b0;
                    was_reg  <= 1'b0;
                    ev_reg   <= 4'h0;
                end else begin
                    dur_reg  <= dur_next;
                    rep_reg  <= rep_next;
                    held_reg <= held_next;
                    was_reg  <= was_next;
                    ev_reg   <= ev_next;
                end
            end
            assign recal_req[ch]        = ev_reg[0];
            assign press_hold_event[ch] = ev_reg[1];
            assign touch_event[ch]      = ev_reg[2];
            assign repeat_pulse[ch]     = ev_reg[3];
        end
    endgenerate

    // sensing cycle sequencer
    ttc_state_t  state_reg, state_next;
    logic [3:0]  scan_reg, scan_next;
    logic [7:0]  cnt_reg, cnt_next;
    logic [22:0] acc_reg, acc_next;
    logic [19:0] tmr_reg, tmr_next;
    logic [13:0] cyc_reg, cyc_next;
    logic        start_reg, start_next;
    logic [1:0]  sdur_reg, sdur_next;
    ttc_result_t res_reg, res_next;
    logic [19:0] samp_len;
    logic [7:0]  samp_last;
    logic [22:0] acc_sum;
    // longer sample selection doubles the window
    assign samp_len  = 20'(SAMP_CYCLES) << sdur_reg;
    assign samp_last = 8'((9'h001 << sample_count_sel) - 9'h001);
    assign acc_sum   = acc_reg + {7'h00, sample_value};

    always_comb begin
        state_next   = state_reg;
        scan_next    = scan_reg;
        cnt_next     = cnt_reg;
        acc_next     = acc_reg;
        tmr_next     = tmr_reg;
        start_next   = 1'b0;
        sdur_next    = sdur_reg;
        res_next     = res_reg;
        res_next.valid = 1'b0;
        cyc_next     = (ms_tick && cyc_reg != 14'h3FFF) ?
                       cyc_reg + 14'h0001 : cyc_reg;
        case (state_reg)
            TTC_ST_SCAN: begin
                if (scan_reg[3]) begin
                    state_next = TTC_ST_WAIT;
                end else if (active_enable[scan_reg[2:0]]) begin
                    state_next = TTC_ST_SAMPLE;
                    cnt_next   = 8'h00;
                    acc_next   = 23'h00_0000;
                    tmr_next   = 20'h0_0000;
                    start_next = 1'b1;
                    sdur_next  = dur_sel;
                end else begin
                    scan_next = scan_reg + 4'h1;
                end
            end
            TTC_ST_SAMPLE: begin
                tmr_next = tmr_reg + 20'h0_0001;
                if (tmr_reg == samp_len - 20'h0_0001) begin
                    acc_next = acc_sum;
                    tmr_next = 20'h0_0000;
                    // back to back, result only when averaged
                    if (cnt_reg == samp_last) begin
                        res_next.valid   = 1'b1;
                        res_next.channel = scan_reg[2:0];
                        res_next.value   = 16'(acc_sum >> sample_count_sel);
                        scan_next  = scan_reg + 4'h1;
                        state_next = TTC_ST_SCAN;
                    end else begin
                        cnt_next   = cnt_reg + 8'h01;
                        start_next = 1'b1;
                    end
                end
            end
            TTC_ST_WAIT: begin
                // low power until cycle time, stretched if sampling ran long
                if (cyc_reg >= cycle_ms) begin
                    cyc_next   = 14'h0000;
                    scan_next  = 4'h0;
                    state_next = TTC_ST_SCAN;
                end
            end
            default: state_next = TTC_ST_SCAN;
        endcase
    end

    // sequencer registers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_reg <= TTC_ST_SCAN;
            scan_reg  <= 4'h0;
            cnt_reg   <= 8'h00;
            acc_reg   <= 23'h00_0000;
            tmr_reg   <= 20'h0_0000;
            cyc_reg   <= 14'h0000;
            start_reg <= 1'b0;
            sdur_reg  <= 2'h0;
            res_reg   <= '0;
        end else begin
            state_reg <= state_next;
            scan_reg  <= scan_next;
            cnt_reg   <= cnt_next;
            acc_reg   <= acc_next;
            tmr_reg   <= tmr_next;
            cyc_reg   <= cyc_next;
            start_reg <= start_next;
            sdur_reg  <= sdur_next;
            res_reg   <= res_next;
        end
    end

    assign sample_start        = start_reg;
    assign sample_channel      = scan_reg[2:0];
    assign sample_duration_sel = sdur_reg;
    assign low_power           = (state_reg == TTC_ST_WAIT);
    assign result              = res_reg;
endmodule : ttc_touch_timing

//--- testbench/ttc_host_model.sv
`timescale 1ns/1ns
module ttc_host_model (
    input  wire logic             clock,
    input  wire logic [7:0]       rd_data,
    output ttc_pkg::ttc_reg_req_t reg_req,
    output logic [7:0]            rd_addr
);
    import ttc_pkg::*;
    // idle bus before the first access
    initial begin
        reg_req = '0;
        rd_addr = 8'h00;
    end
    // caller stands just after an edge; one edge per access
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_req = '{wr_en: 1'b1, addr: a, wdata: d};
        @(posedge clock);
        #1;
        reg_req.wr_en = 1'b0;
        reg_req.wdata = ~d; // stale data must not look valid
    endtask : wr
    // read data is registered, so it lands one edge after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        rd_addr = a;
        @(posedge clock);
        #1;
        d = rd_data;
    endtask : rd
endmodule : ttc_host_model

//--- testbench/ttc_touch_timing_asserts.sv
`timescale 1ns/1ns
module ttc_touch_timing_asserts #(
    parameter int MS_CYCLES   = 10,
    parameter int SAMP_CYCLES = 4
) (
    input wire logic                  clock,
    input wire logic                  reset,
    input wire ttc_pkg::ttc_reg_req_t reg_req,
    input wire logic [7:0]            rd_data,
    input wire logic [7:0]            rd_addr,
    input wire logic                  hold_limit_recal_enable,
    input wire logic [7:0]            touched,
    input wire logic [7:0]            recal_req,
    input wire logic [7:0]            press_hold_event,
    input wire logic [7:0]            touch_event,
    input wire logic                  sample_start,
    input wire logic                  low_power,
    input wire ttc_pkg::ttc_result_t  result
);
    import ttc_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // register map and masks seen at the read port
    unmapped_zero_a: assert property (!(rd_addr inside {8'h22, 8'h23, 8'h24})
        |=> rd_data == 8'h00) else $error("unmapped read not zero");
    dur_readback_a: assert property (reg_req.wr_en && reg_req.addr == 8'h22
        ##1 rd_addr == 8'h22 |=> rd_data == $past(reg_req.wdata, 2))
        else $error("timing register readback wrong");
    press_mask_a: assert property (reg_req.wr_en && reg_req.addr == 8'h23
        ##1 rd_addr == 8'h23 |=> rd_data == ($past(reg_req.wdata, 2) & 8'h0f))
        else $error("press register readback wrong");
    avg_mask_a: assert property (reg_req.wr_en && reg_req.addr == 8'h24
        ##1 rd_addr == 8'h24 |=> rd_data == ($past(reg_req.wdata, 2) & 8'h7f))
        else $error("averaging register readback wrong");
    // event classification and the recalibration gate
    recal_gated_a: assert property (!hold_limit_recal_enable [*3]
        |=> recal_req == 8'h00) else $error("recal while disabled");
    hold_needs_touch_a: assert property ((press_hold_event
        & ~($past(touched, 2) | $past(touched, 3))) == 8'h00)
        else $error("press hold without touch");
    one_class_a: assert property ((press_hold_event & touch_event) == 8'h00)
        else $error("touch classed twice");
    // sequencer pacing: windows are at least four cycles long
    window_gap_a: assert property (sample_start |=> !sample_start [*3])
        else $error("sample windows too close");
    idle_quiet_a: assert property (low_power |-> !sample_start)
        else $error("sampling while idle");
    result_pulse_a: assert property (result.valid |=> !result.valid)
        else $error("result valid too long");
    c_press: cover property (press_hold_event[0]);
    c_recal: cover property (recal_req[0]);
    c_touch: cover property (touch_event[0]);
    c_result: cover property (result.valid);
endmodule : ttc_touch_timing_asserts
bind ttc_touch_timing ttc_touch_timing_asserts #(.MS_CYCLES(MS_CYCLES),
    .SAMP_CYCLES(SAMP_CYCLES)) ttc_touch_timing_asserts_inst (
    .clock(clock), .reset(reset), .reg_req(reg_req), .rd_data(rd_data),
    .rd_addr(rd_addr), .hold_limit_recal_enable(hold_limit_recal_enable),
    .touched(touched), .recal_req(recal_req),
    .press_hold_event(press_hold_event), .touch_event(touch_event),
    .sample_start(sample_start), .low_power(low_power), .result(result));

//--- testbench/test_touch_timing_config.sv
`timescale 1ns/1ns
module test_touch_timing_config;
    import ttc_pkg::*;
    localparam int MS = 10;
    logic         clock = 1'b0;
    logic         reset = 1'b1;
    ttc_reg_req_t reg_req;
    ttc_result_t  res;
    logic [7:0]   rd_addr, rd_data, act, rpt, tch, recal, phe, tev, rpl, a, d, r;
    logic [15:0]  sval;
    logic [2:0]   ac, ch, sch;
    logic [1:0]   sds, sd;
    logic         en, sst, st, lpw, lp;
    int           n_errors = 0, num_checks = 0, n, t, ns, pc, rc;
    logic [7:0]   rv [5] = '{8'h00, 8'ha4, 8'h07, 8'h39, 8'h00};

    always #10 clock = ~clock;
    ttc_host_model ttc_host_model_inst (.clock(clock), .rd_data(rd_data),
        .reg_req(reg_req), .rd_addr(rd_addr));
    ttc_touch_timing #(.MS_CYCLES(MS), .SAMP_CYCLES(4)) ttc_touch_timing_inst (
        .clock(clock), .reset(reset), .reg_req(reg_req), .rd_data(rd_data),
        .rd_addr_lo(3'b000), .rd_addr(rd_addr), .hold_limit_recal_enable(en),
        .active_enable(act), .repeat_enable(rpt), .touched(tch),
        .sample_value(sval), .recal_req(recal), .press_hold_event(phe),
        .touch_event(tev), .repeat_pulse(rpl), .sample_start(sst),
        .sample_channel(sch), .sample_duration_sel(sds), .low_power(lpw),
        .result(res));

    task automatic check(input string what, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    // reserved bits read back as zero, unmapped places as zero
    function automatic logic [7:0] exp_reg(input logic [7:0] a, d);
        case (a)
            8'h22: return d;
            8'h23: return d & 8'h0f;
            8'h24: return d & 8'h7f;
            default: return 8'h00;
        endcase
    endfunction : exp_reg
    // p ms ticks from a free-running tick: up to one tick of phase slack
    function automatic logic in_ms(input int n, p);
        return n > (p - 1) * MS && n <= p * MS + 3;
    endfunction : in_ms
    // cycles until bit 0 of the chosen pulse, bounded by lim
    task automatic wait_ev(input int s, input int lim, output int n);
        logic [7:0] v;
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
            // selector 4 waits for a finished average
            v = s == 0 ? phe : s == 1 ? rpl : s == 2 ? recal :
                s == 3 ? tev : {7'h00, res.valid};
            ns += int'(sst === 1'b1);
            lp = lp | (lpw === 1'b1);
        end while (v[0] !== 1'b1 && n < lim);
    endtask : wait_ev
    // span covers every scenario with ample margin
    initial begin
        repeat (60000) @(posedge clock);
        n_errors++;
        conclude();
    end

    initial begin
        void'($urandom(32'he732));
        en = 1'b1;
        act = 8'($urandom) | 8'h01;
        rpt = 8'hff;
        tch = 8'h00;
        sval = 16'($urandom);
        repeat (8) @(posedge clock);
        #1;
        reset = 1'b0;
        for (int i = 0; i < 5; i++) begin
            ttc_host_model_inst.rd(8'h21 + 8'(i), r);
            check("reset value", r, rv[i]);
        end
        // random writes, masks and unmapped places
        repeat (16) begin
            a = 8'h21 + 8'($urandom % 5);
            d = 8'($urandom);
            ttc_host_model_inst.wr(a, d);
            ttc_host_model_inst.rd(a, r);
            check("readback", r, exp_reg(a, d));
        end
        reset = 1'b1;
        @(posedge clock);
        #1;
        reset = 1'b0;
        ttc_host_model_inst.rd(8'h22, r);
        check("second reset", r, 8'ha4);
        // short touch is an ordinary touch
        pc = $urandom % 4;
        rc = $urandom % 4;
        ttc_host_model_inst.wr(8'h22, 8'(rc));
        ttc_host_model_inst.wr(8'h23, 8'(pc));
        tch = 8'h01;
        repeat (((pc + 1) * 35 - 2) * MS) @(posedge clock);
        #1;
        tch = 8'h00;
        wait_ev(3, 10, n);
        check("touch event", 16'(n < 10), 16'h0001);
        // long touch timings restart from the new touch
        tch = 8'h01;
        wait_ev(0, 700 * MS, n);
        check("press delay", 16'(in_ms(n, (pc + 1) * 35 + 1)), 16'h0001);
        t = n;
        repeat (2) begin
            wait_ev(1, 700 * MS, n);
            check("repeat gap", 16'(n), 16'((rc + 1) * 35 * MS));
            t += n;
        end
        wait_ev(2, 700 * MS, n);
        check("recal delay", 16'(in_ms(t + n, 560)), 16'h0001);
        tch = 8'h00;
        en = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        tch = 8'h01;
        wait_ev(2, 580 * MS, n);
        check("recal disabled", 16'(n), 16'(580 * MS));
        tch = 8'h00;
        ac = 3'($urandom % 3);
        sd = 2'($urandom);
        ttc_host_model_inst.wr(8'h24, {1'b0, ac, sd, 2'b00});
        st = 1'b0;
        lp = 1'b0;
        repeat (18) begin
            ns = 0;
            wait_ev(4, 5000, n);
            check("result wait", 16'(n < 5000), 16'h0001);
            if (st) begin
                do ch = ch + 3'd1; while (act[ch] !== 1'b1);
                check("scan channel", 16'(sch), 16'(ch + 3'd1));
                check("result channel", 16'(res.channel), 16'(ch));
                check("result value", res.value, sval);
                check("samples", 16'(ns), 16'(1 << ac));
                check("sample duration", 16'(sds), 16'(sd));
            end
            if (!st && res.channel === 3'd0) begin
                st = 1'b1;
                ch = 3'd0;
            end
        end
        check("idle seen", 16'(lp), 16'h0001);
        conclude();
    end
endmodule : test_touch_timing_config
